// >>> dtc_phase.sv
// machine cycle phase generator: one-cycle phase strobes
// assumes pclk is the oscillator; one machine cycle is CYCLE_LEN clocks
`timescale 1ns/1ps
module dtc_phase #(
  parameter int unsigned CYCLE_LEN = dtc_pkg::OSC_PER_MC
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic increment_phase,
  output logic flag_phase,
  output logic sample_phase
);

  if (CYCLE_LEN < 10 || CYCLE_LEN > 16) begin : g_bad_len
    $error("dtc_phase: CYCLE_LEN out of range");
  end

  typedef struct packed {
    logic [3:0] cnt;
    logic inc;
    logic flg;
    logic smp;
  } dtc_phase_state_t;

  dtc_phase_state_t s;
  dtc_phase_state_t next_s;
  localparam logic [3:0] LAST = 4'(CYCLE_LEN - 1);

  // ----------------------------------------
  // state positions within a machine cycle
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.cnt = (s.cnt == LAST) ? 4'h0 : s.cnt + 4'h1;
    next_s.inc = (next_s.cnt == dtc_pkg::PH_INCREMENT);
    next_s.flg = (next_s.cnt == dtc_pkg::PH_FLAG);
    next_s.smp = (next_s.cnt == dtc_pkg::PH_SAMPLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign increment_phase = s.inc;
  assign flag_phase = s.flg;
  assign sample_phase = s.smp;

endmodule

// >>> dtc_pin_model.sv
// far-side model of one count input pin: one falling transition per request
// assumes the bench pulses fire for one pclk while busy is low
`timescale 1ns/1ps
module dtc_pin_model #(
  parameter int unsigned HOLD = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  output logic busy,
  output logic pin
);
  int unsigned cnt;

  // ----------------------------------------
  // low for HOLD+1 clocks, then high; busy until 2*HOLD clocks after the fall
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      pin <= 1'b1;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      pin <= (cnt <= HOLD);
    end else if (fire) begin
      cnt <= 2 * HOLD;
      pin <= 1'b0;
    end
  end

  assign busy = (cnt != 0);
endmodule

// >>> dtc_pkg.sv
// constants for the dual timer/counter with cascade
// assumes a 50 MHz pclk standing in for the oscillator, apb register access
package dtc_pkg;

  // ----------------------------------------
  // machine cycle timing
  // ----------------------------------------
  localparam int unsigned OSC_PER_MC = 12;
  localparam logic [3:0] PH_INCREMENT = 4'h4;
  localparam logic [3:0] PH_FLAG = 4'h8;
  localparam logic [3:0] PH_SAMPLE = 4'h9;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_CL0 = 8'h0c;
  localparam logic [7:0] ADDR_CH0 = 8'h10;
  localparam logic [7:0] ADDR_CL1 = 8'h14;
  localparam logic [7:0] ADDR_CH1 = 8'h18;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned MODE_GATE_FIRST = 3;
  localparam int unsigned MODE_SEL_FIRST = 2;
  localparam int unsigned MODE_GATE_SECOND = 7;
  localparam int unsigned MODE_SEL_SECOND = 6;
  localparam int unsigned CTRL_FLAG_SECOND = 7;
  localparam int unsigned CTRL_RUN_SECOND = 6;
  localparam int unsigned CTRL_FLAG_FIRST = 5;
  localparam int unsigned CTRL_RUN_FIRST = 4;
  localparam int unsigned CFG_CASCADE = 6;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;

  // ----------------------------------------
  // enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } dtc_mode_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } dtc_bus_t;

endpackage

// >>> dtc_timer.sv
// dual 16-bit timer/counter with 32-bit cascade, apb register slave
// assumes pins arrive asynchronously, apb master on pclk, vector acks on pclk
//
// How it works
// - timer function adds one per machine cycle of twelve clocks
// - counter function samples count input at sample phase, counts high-then-low
// - detected fall shows in count at next increment phase
// - one fall needs two machine cycles, so rate at most clock/24
// - mode register: second timer upper nibble, first lower, gate bits 7 and 3
// - select bit clear counts machine cycles, set counts count input
// - counts only with run set and gate off or gate input high
// - mode 0 is 13 bits, high byte plus low five bits, rollover sets flag
// - setting run never touches the count registers
// - mode 1 counts all 16 bits of both bytes
// - mode 2 low byte counts, overflow sets flag and reloads from high byte
// - mode field 00 13-bit, 01 16-bit, 10 reload, 11 split or halt
// - second timer in mode 3 holds as if run were clear
// - first timer mode 3: low byte own controls, high byte uses second run/flag
// - then second timer runs outside its mode 3, no flag, overflow tick out
// - control register: runs at bits 6 and 4, flags at 7 and 5
// - cascade joins timers into 32 bits, first timer low half
// - cascade bit starts and stops 32-bit count; clear returns to own modes
// - 32-bit timer steps at increment phase, carry silent, top sets flag later
// - 32-bit counter uses first count input falls across two samples
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module dtc_timer #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_input_first,
  input wire logic count_input_second,
  input wire logic gate_input_first,
  input wire logic gate_input_second,
  input wire logic vector_ack_first,
  input wire logic vector_ack_second,
  output logic overflow_flag_first,
  output logic overflow_flag_second,
  output logic second_overflow_tick
);

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("dtc_timer: ADDR_W out of range");
  end

  typedef struct packed {
    dtc_pkg::dtc_bus_t bus;
    logic [31:0] rdata;
    logic err;
    logic [7:0] mode;
    logic [7:4] ctrl;
    logic [7:0] cfg;
    logic [7:0] cl0;
    logic [7:0] ch0;
    logic [7:0] cl1;
    logic [7:0] ch1;
    logic [2:0][3:0] sync;
    logic [3:0] lvl;
    logic [1:0] smp;
    logic [1:0] pend;
    logic pend32;
    logic tick;
  } dtc_state_t;

  dtc_state_t s;
  dtc_state_t next_s;
  logic inc_ph;
  logic flg_ph;
  logic smp_ph;
  logic tick0;
  logic tick1;
  logic gok0;
  logic gok1;
  logic [16:0] r0;
  logic [16:0] r1;
  logic [32:0] sum32;
  logic [8:0] sum8;
  logic wr_any;

  // ----------------------------------------
  // machine cycle phases
  // ----------------------------------------
  dtc_phase #(
    .CYCLE_LEN(dtc_pkg::OSC_PER_MC)
  ) u_phase (
    .pclk(pclk),
    .presetn(presetn),
    .increment_phase(inc_ph),
    .flag_phase(flg_ph),
    .sample_phase(smp_ph)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [7:0] lo;
    begin
      lo = a[7:0];
      addr_hit = (a[ADDR_W-1:0] >> 8) == '0 && lo <= dtc_pkg::ADDR_CH1 && lo[1:0] == 2'b00;
    end
  endfunction

  // one step of a timer in modes 0..2; returns overflow, high, low
  function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] hi,
                                       input logic [7:0] lo);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    begin
      s13 = {1'b0, hi, lo[4:0]} + 14'h1;
      s16 = {1'b0, hi, lo} + 17'h1;
      s8 = {1'b0, lo} + 9'h1;
      case (m)
        dtc_pkg::MODE_13BIT: step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
        dtc_pkg::MODE_16BIT: step = s16;
        dtc_pkg::MODE_RELOAD: step = s8[8] ? {1'b1, hi, hi} : {1'b0, hi, s8[7:0]};
        default: step = {1'b0, hi, lo};
      endcase
    end
  endfunction

  assign wr_any = psel && penable && pwrite && s.bus == dtc_pkg::BUS_ANSWER;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    tick0 = 1'b0;
    tick1 = 1'b0;
    gok0 = 1'b0;
    gok1 = 1'b0;
    r0 = '0;
    r1 = '0;
    sum32 = '0;
    sum8 = '0;
    next_s.tick = 1'b0;
    // pin synchronisers, level moves once stages two and three agree
    next_s.sync = {s.sync[1:0],
                   {gate_input_second, gate_input_first, count_input_second, count_input_first}};
    for (int i = 0; i < 4; i++) begin
      if (s.sync[1][i] == s.sync[2][i]) begin
        next_s.lvl[i] = s.sync[2][i];
      end
    end
    // vector clears, overridden below by any set
    if (vector_ack_first) begin
      next_s.ctrl[dtc_pkg::CTRL_FLAG_FIRST] = 1'b0;
    end
    if (vector_ack_second) begin
      next_s.ctrl[dtc_pkg::CTRL_FLAG_SECOND] = 1'b0;
    end
    // falling edge across two samples
    if (smp_ph) begin
      next_s.smp = s.lvl[1:0];
      for (int i = 0; i < 2; i++) begin
        if (s.smp[i] && !s.lvl[i]) begin
          next_s.pend[i] = 1'b1;
        end
      end
    end
    if (inc_ph) begin
      next_s.pend = 2'b00;
      tick0 = s.mode[dtc_pkg::MODE_SEL_FIRST] ? s.pend[0] : 1'b1;
      tick1 = s.mode[dtc_pkg::MODE_SEL_SECOND] ? s.pend[1] : 1'b1;
      gok0 = !s.mode[dtc_pkg::MODE_GATE_FIRST] || s.lvl[2];
      gok1 = !s.mode[dtc_pkg::MODE_GATE_SECOND] || s.lvl[3];
      if (s.cfg[dtc_pkg::CFG_CASCADE]) begin
        if (tick0 && gok0) begin
          sum32 = {1'b0, s.ch1, s.cl1, s.ch0, s.cl0} + 33'h1;
          {next_s.ch1, next_s.cl1, next_s.ch0, next_s.cl0} = sum32[31:0];
          if (sum32[32]) begin
            next_s.pend32 = 1'b1;
          end
        end
      end else if (s.mode[1:0] == dtc_pkg::MODE_SPLIT) begin
        if (s.ctrl[dtc_pkg::CTRL_RUN_FIRST] && gok0 && tick0) begin
          sum8 = {1'b0, s.cl0} + 9'h1;
          next_s.cl0 = sum8[7:0];
          if (sum8[8]) begin
            next_s.ctrl[dtc_pkg::CTRL_FLAG_FIRST] = 1'b1;
          end
        end
        if (s.ctrl[dtc_pkg::CTRL_RUN_SECOND]) begin
          r0 = {8'h00, 1'b0, s.ch0} + 17'h1;
          next_s.ch0 = r0[7:0];
          if (r0[8]) begin
            next_s.ctrl[dtc_pkg::CTRL_FLAG_SECOND] = 1'b1;
          end
        end
        if (s.mode[5:4] != dtc_pkg::MODE_SPLIT && gok1 && tick1) begin
          r1 = step(s.mode[5:4], s.ch1, s.cl1);
          {next_s.ch1, next_s.cl1} = r1[15:0];
          next_s.tick = r1[16];
        end
      end else begin
        if (s.ctrl[dtc_pkg::CTRL_RUN_FIRST] && gok0 && tick0) begin
          r0 = step(s.mode[1:0], s.ch0, s.cl0);
          {next_s.ch0, next_s.cl0} = r0[15:0];
          if (r0[16]) begin
            next_s.ctrl[dtc_pkg::CTRL_FLAG_FIRST] = 1'b1;
          end
        end
        if (s.mode[5:4] != dtc_pkg::MODE_SPLIT && s.ctrl[dtc_pkg::CTRL_RUN_SECOND] && gok1
            && tick1) begin
          r1 = step(s.mode[5:4], s.ch1, s.cl1);
          {next_s.ch1, next_s.cl1} = r1[15:0];
          next_s.tick = r1[16];
          if (r1[16]) begin
            next_s.ctrl[dtc_pkg::CTRL_FLAG_SECOND] = 1'b1;
          end
        end
      end
    end
    if (flg_ph && s.pend32) begin
      next_s.pend32 = 1'b0;
      next_s.ctrl[dtc_pkg::CTRL_FLAG_SECOND] = 1'b1;
    end
    // apb slave: read data latched in first access cycle, write on answer edge
    case (s.bus)
      dtc_pkg::BUS_IDLE: begin
        if (psel && penable) begin
          next_s.bus = dtc_pkg::BUS_ANSWER;
          next_s.err = !addr_hit(paddr);
          next_s.rdata = 32'h0000_0000;
          case (paddr[7:0])
            dtc_pkg::ADDR_MODE: next_s.rdata[7:0] = s.mode;
            dtc_pkg::ADDR_CONTROL: next_s.rdata[7:0] = {s.ctrl, 4'h0};
            dtc_pkg::ADDR_CONFIG: next_s.rdata[7:0] = s.cfg;
            dtc_pkg::ADDR_CL0: next_s.rdata[7:0] = s.cl0;
            dtc_pkg::ADDR_CH0: next_s.rdata[7:0] = s.ch0;
            dtc_pkg::ADDR_CL1: next_s.rdata[7:0] = s.cl1;
            dtc_pkg::ADDR_CH1: next_s.rdata[7:0] = s.ch1;
            default: next_s.rdata = 32'h0000_0000;
          endcase
        end
      end
      dtc_pkg::BUS_ANSWER: begin
        next_s.bus = dtc_pkg::BUS_IDLE;
        next_s.err = 1'b0;
        if (pwrite && !s.err && pstrb[0]) begin
          case (paddr[7:0])
            dtc_pkg::ADDR_MODE: next_s.mode = pwdata[7:0];
            dtc_pkg::ADDR_CONTROL: next_s.ctrl = pwdata[7:4];
            dtc_pkg::ADDR_CONFIG: next_s.cfg = pwdata[7:0];
            dtc_pkg::ADDR_CL0: next_s.cl0 = pwdata[7:0];
            dtc_pkg::ADDR_CH0: next_s.ch0 = pwdata[7:0];
            dtc_pkg::ADDR_CL1: next_s.cl1 = pwdata[7:0];
            dtc_pkg::ADDR_CH1: next_s.ch1 = pwdata[7:0];
            default: next_s.mode = next_s.mode;
          endcase
        end
      end
      default: next_s.bus = dtc_pkg::BUS_IDLE;
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.bus <= dtc_pkg::BUS_IDLE;
      s.mode <= dtc_pkg::RST_MODE;
      s.ctrl <= dtc_pkg::RST_CONTROL[7:4];
      s.cfg <= dtc_pkg::RST_CONFIG;
      s.cl0 <= dtc_pkg::RST_COUNT;
      s.ch0 <= dtc_pkg::RST_COUNT;
      s.cl1 <= dtc_pkg::RST_COUNT;
      s.ch1 <= dtc_pkg::RST_COUNT;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.rdata;
  assign pready = s.bus[1];
  assign pslverr = s.err;
  assign overflow_flag_first = s.ctrl[dtc_pkg::CTRL_FLAG_FIRST];
  assign overflow_flag_second = s.ctrl[dtc_pkg::CTRL_FLAG_SECOND];
  assign second_overflow_tick = s.tick;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held more than one cycle");
  error_answer_a: assert property (pslverr |-> pready)
    else $error("pslverr outside an answer");
  timer_rate_a: assert property (
      inc_ph && !s.cfg[6] && s.mode[3:0] == 4'h1 && s.ctrl[4] && !wr_any
      |=> {s.ch0, s.cl0} == $past({s.ch0, s.cl0}) + 16'h1)
    else $error("mode 1 timer did not step");
  count_phase_a: assert property (!inc_ph && !wr_any |=> $stable({s.ch0, s.cl0}))
    else $error("first count moved off increment phase");
  edge_pend_a: assert property (smp_ph && s.smp[0] && !s.lvl[0] |=> s.pend[0])
    else $error("falling sample not recorded");
  run_gate_a: assert property (
      inc_ph && !s.cfg[6] && s.mode[1:0] != 2'b11 && !s.ctrl[4] && !wr_any
      |=> $stable({s.ch0, s.cl0}))
    else $error("first timer counted while stopped");
  gate_block_a: assert property (
      inc_ph && !s.cfg[6] && s.mode[1:0] != 2'b11 && s.mode[3] && !s.lvl[2] && !wr_any
      |=> $stable({s.ch0, s.cl0}))
    else $error("first timer counted with gate input low");
  mode2_reload_a: assert property (
      inc_ph && !s.cfg[6] && s.mode[3:0] == 4'h2 && s.ctrl[4] && s.cl0 == 8'hff && !wr_any
      |=> s.cl0 == $past(s.ch0) && overflow_flag_first)
    else $error("mode 2 reload missing");
  mode0_roll_a: assert property (
      inc_ph && !s.cfg[6] && s.mode[3:0] == 4'h0 && s.ctrl[4] && s.ch0 == 8'hff
      && s.cl0[4:0] == 5'h1f && !wr_any
      |=> s.ch0 == 8'h00 && s.cl0[4:0] == 5'h00 && overflow_flag_first)
    else $error("13-bit rollover wrong");
  flag_wins_a: assert property (
      inc_ph && !s.cfg[6] && s.mode[3:0] == 4'h1 && s.ctrl[4] && {s.ch0, s.cl0} == 16'hffff
      && !wr_any |=> overflow_flag_first)
    else $error("overflow flag lost");
  second_hold_a: assert property (
      s.mode[5:4] == 2'b11 && !s.cfg[6] && !wr_any |=> $stable({s.ch1, s.cl1}))
    else $error("second timer moved in mode 3");
  split_high_a: assert property (
      inc_ph && !s.cfg[6] && s.mode[1:0] == 2'b11 && s.ctrl[6] && !wr_any
      |=> s.ch0 == $past(s.ch0) + 8'h1)
    else $error("split high byte did not step");
  cascade_step_a: assert property (
      inc_ph && s.cfg[6] && s.mode[3:2] == 2'b00 && !wr_any
      |=> {s.ch1, s.cl1, s.ch0, s.cl0} == $past({s.ch1, s.cl1, s.ch0, s.cl0}) + 32'h1)
    else $error("32-bit timer did not step");
  cascade_quiet_a: assert property (
      s.cfg[6] && !overflow_flag_first && !wr_any |=> !overflow_flag_first)
    else $error("carry out of low half set the first flag");
  cascade_flag_a: assert property (s.pend32 && flg_ph && !wr_any |=> overflow_flag_second)
    else $error("32-bit overflow flag not set");

endmodule

// >>> tb_top.sv
// self-checking bench for the dual timer/counter: apb tasks and test sequences
// assumes dtc_pkg, dtc_timer and dtc_pin_model are compiled first
`timescale 1ns/1ps
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin n_errors++; \
  $display("Error t=%0t got %h exp %h", $time, g, x); end end
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, cin1, cin2, flag1, flag2, busy1, busy2, tick;
  logic gate1 = 1'b0;
  logic gate2 = 1'b0;
  logic ack1 = 1'b0;
  logic ack2 = 1'b0;
  logic fire1 = 1'b0;
  logic fire2 = 1'b0;
  logic [7:0] q;
  logic e;
  int n_errors = 0;
  int checks_done = 0;
  int n_tick = 0;

  always #10 pclk = ~pclk;

  always @(posedge pclk) begin
    if (tick === 1'b1) n_tick++;
  end

  dtc_timer u_dtc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_input_first(cin1), .count_input_second(cin2),
    .gate_input_first(gate1), .gate_input_second(gate2), .vector_ack_first(ack1),
    .vector_ack_second(ack2), .overflow_flag_first(flag1), .overflow_flag_second(flag2),
    .second_overflow_tick(tick));
  dtc_pin_model u_dtc_pin_model_first (.pclk(pclk), .presetn(presetn), .fire(fire1),
    .busy(busy1), .pin(cin1));
  dtc_pin_model u_dtc_pin_model_second (.pclk(pclk), .presetn(presetn), .fire(fire2),
    .busy(busy2), .pin(cin2));

  // ----------------------------------------
  // bus and helper tasks
  // ----------------------------------------
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      $display("Error t=%0t apb answer missing", $time);
    end
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
    apb(a, 1'b0, 8'h00);
    `CHK(q, x)
  endtask

  task automatic wait_hi(input logic sec);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((sec ? flag2 : flag1) !== 1'b1 && n < 1000);
    `CHK(n < 1000, 1'b1)
  endtask

  task automatic pulses(input int k, input logic a, input logic b);
    int n;
    repeat (k) begin
      fire1 <= a;
      fire2 <= b;
      @(posedge pclk);
      fire1 <= 1'b0;
      fire2 <= 1'b0;
      @(posedge pclk);
      for (n = 0; n < 200 && (busy1 || busy2); n++) @(posedge pclk);
    end
  endtask

  // preload, run, catch the flag, ack it, stop 20 machine cycles later
  task automatic run_case(input logic [7:0] mode, input logic [7:0] run,
      input logic [7:0] la, input logic [7:0] lo, input logic [7:0] hi, input logic sec,
      input logic [7:0] xlo, input logic [7:0] xhi, input logic [7:0] mask);
    wr(la, lo);
    wr(la + 8'h04, hi);
    wr(dtc_pkg::ADDR_MODE, mode);
    wr(dtc_pkg::ADDR_CONTROL, run);
    wait_hi(sec);
    ack1 <= !sec;
    ack2 <= sec;
    @(posedge pclk);
    ack1 <= 1'b0;
    ack2 <= 1'b0;
    @(posedge pclk);
    `CHK(sec ? flag2 : flag1, 1'b0)
    repeat (236) @(posedge pclk);
    wr(dtc_pkg::ADDR_CONTROL, 8'h00);
    apb(la, 1'b0, 8'h00);
    `CHK(q & mask, xlo)
    rd_chk(la + 8'h04, xhi);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) rd_chk(8'(4 * i), dtc_pkg::RST_COUNT);
    apb(8'h1c, 1'b0, 8'h00);
    `CHK(e, 1'b1)
    `CHK(q, 8'h00)
    wr(dtc_pkg::ADDR_CONFIG, 8'h3f);
    rd_chk(dtc_pkg::ADDR_CONFIG, 8'h3f);
    wr(dtc_pkg::ADDR_CONFIG, 8'h00);
    wr(dtc_pkg::ADDR_CONTROL, 8'h0f);
    rd_chk(dtc_pkg::ADDR_CONTROL, 8'h00);
    wr(dtc_pkg::ADDR_MODE, 8'ha5);
    rd_chk(dtc_pkg::ADDR_MODE, 8'ha5);
    $display("test registers done");
    gate1 <= 1'b1;
    run_case(8'h01, 8'h10, dtc_pkg::ADDR_CL0, 8'hfe, 8'hff, 1'b0, 8'h14, 8'h00, 8'hff);
    run_case(8'h00, 8'h10, dtc_pkg::ADDR_CL0, 8'hfe, 8'hff, 1'b0, 8'h14, 8'h00, 8'h1f);
    run_case(8'h02, 8'h10, dtc_pkg::ADDR_CL0, 8'hfe, 8'h80, 1'b0, 8'h94, 8'h80, 8'hff);
    run_case(8'h09, 8'h10, dtc_pkg::ADDR_CL0, 8'hfe, 8'hff, 1'b0, 8'h14, 8'h00, 8'hff);
    run_case(8'h10, 8'h40, dtc_pkg::ADDR_CL1, 8'hfe, 8'hff, 1'b1, 8'h14, 8'h00, 8'hff);
    run_case(8'h03, 8'h40, dtc_pkg::ADDR_CL0, 8'h00, 8'hfe, 1'b1, 8'h00, 8'h14, 8'hff);
    `CHK(n_tick, 1)
    $display("test modes done");
    gate1 <= 1'b0;
    wr(dtc_pkg::ADDR_MODE, 8'h39);
    wr(dtc_pkg::ADDR_CL0, 8'h5a);
    wr(dtc_pkg::ADDR_CL1, 8'h5a);
    wr(dtc_pkg::ADDR_CONTROL, 8'h50);
    repeat (100) @(posedge pclk);
    rd_chk(dtc_pkg::ADDR_CL0, 8'h5a);
    rd_chk(dtc_pkg::ADDR_CL1, 8'h5a);
    $display("test hold done");
    wr(dtc_pkg::ADDR_CONTROL, 8'h00);
    wr(dtc_pkg::ADDR_MODE, 8'h55);
    for (int i = 3; i < 7; i++) wr(8'(4 * i), 8'h00);
    wr(dtc_pkg::ADDR_CONTROL, 8'h50);
    pulses(5, 1'b1, 1'b1);
    repeat (40) @(posedge pclk);
    rd_chk(dtc_pkg::ADDR_CL0, 8'h05);
    rd_chk(dtc_pkg::ADDR_CL1, 8'h05);
    $display("test counter done");
    wr(dtc_pkg::ADDR_CONTROL, 8'h00);
    wr(dtc_pkg::ADDR_MODE, 8'h00);
    wr(dtc_pkg::ADDR_CL0, 8'hfe);
    for (int i = 4; i < 7; i++) wr(8'(4 * i), 8'hff);
    wr(dtc_pkg::ADDR_CONFIG, 8'h40);
    wait_hi(1'b1);
    `CHK(flag1, 1'b0)
    wr(dtc_pkg::ADDR_CONFIG, 8'h00);
    for (int i = 3; i < 7; i++) rd_chk(8'(4 * i), 8'h00);
    repeat (40) @(posedge pclk);
    rd_chk(dtc_pkg::ADDR_CL0, 8'h00);
    wr(dtc_pkg::ADDR_MODE, 8'h04);
    wr(dtc_pkg::ADDR_CONFIG, 8'h40);
    pulses(3, 1'b1, 1'b0);
    repeat (40) @(posedge pclk);
    wr(dtc_pkg::ADDR_CONFIG, 8'h00);
    rd_chk(dtc_pkg::ADDR_CL0, 8'h03);
    $display("test cascade done");
    print_verdict();
  end
endmodule
